//--- logic/atc_pkg.sv
// Package for the alert threshold compare block: register map, fields, reset values
package atc_pkg;
  localparam int          ATC_NUM_CH        = 4;
  localparam int          ATC_RES_W         = 16;
  localparam int          ATC_LIM_W         = 12;
  localparam int          ATC_SEL_W         = 4;
  localparam int          ATC_FLAG_W        = 2 * ATC_NUM_CH;
  localparam int          ATC_IRQ_W         = 2;
  // Register byte addresses
  localparam logic [7:0]  ATC_ADDR_STATUS   = 8'h00;
  localparam logic [7:0]  ATC_ADDR_LOWER    = 8'h04;
  localparam logic [7:0]  ATC_ADDR_UPPER    = 8'h08;
  localparam logic [7:0]  ATC_ADDR_IRQ_STAT = 8'h0c;
  localparam logic [7:0]  ATC_ADDR_IRQ_MASK = 8'h10;
  // Field layout of the limit registers
  localparam int          ATC_SEL_LSB       = 12;
  localparam int          ATC_LIM_LSB       = 4;
  localparam int          ATC_UNDER_BIT     = 0;
  localparam int          ATC_OVER_BIT      = 1;
  localparam logic [3:0]  ATC_LOW_FILL      = 4'h0;
  localparam logic [3:0]  ATC_HIGH_FILL     = 4'hf;
  // Reset values
  localparam logic [11:0] ATC_LOWER_RST     = 12'h800;
  localparam logic [11:0] ATC_UPPER_RST     = 12'h7ff;
  localparam logic [3:0]  ATC_LOWER_SEL_RST = 4'h0;
  localparam logic [3:0]  ATC_UPPER_SEL_RST = 4'h0;
  // Interrupt status bits
  localparam int          ATC_IRQ_UNDER     = 0;
  localparam int          ATC_IRQ_OVER      = 1;
endpackage

//--- logic/atc_chan_cmp.sv
// One channel's limit comparison and sticky over and under flags
`timescale 1ns/1ps
module atc_chan_cmp
  import atc_pkg::*;
#(
  parameter int RES_W = ATC_RES_W
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Conversion result
  input  wire logic             valid_i,
  input  wire logic [RES_W-1:0] result_i,
  // Internal limits
  input  wire logic [RES_W-1:0] low_lim_i,
  input  wire logic [RES_W-1:0] high_lim_i,
  // Read-to-clear
  input  wire logic             clr_i,
  // Flags and events
  output logic                  under_o,
  output logic                  over_o,
  output logic                  under_evt_o,
  output logic                  over_evt_o
);
  logic under_q;
  logic over_q;
  logic under_d;
  logic over_d;

  assign under_evt_o = valid_i && (result_i < low_lim_i);
  assign over_evt_o  = valid_i && (result_i > high_lim_i);
  assign under_d = under_evt_o | (under_q & ~clr_i);
  assign over_d  = over_evt_o | (over_q & ~clr_i);
  assign under_o = under_q;
  assign over_o  = over_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      under_q <= 1'b0;
      over_q  <= 1'b0;
    end else begin
      under_q <= under_d;
      over_q  <= over_d;
    end
  end
endmodule

//--- logic/atc_top.sv
// Alert threshold compare register bank with APB slave and interrupt
`timescale 1ns/1ps
module atc_top
  import atc_pkg::*;
#(
  parameter int NUM_CH = atc_pkg::ATC_NUM_CH,
  parameter int RES_W  = atc_pkg::ATC_RES_W
) (
  // Clock and reset
  input  wire logic                CLK_SYS_I,
  input  wire logic                SYS_RST_I,
  // APB slave
  input  wire logic                PSEL_I,
  input  wire logic                PENABLE_I,
  input  wire logic                PWRITE_I,
  input  wire logic [7:0]          PADDR_I,
  input  wire logic [31:0]         PWDATA_I,
  output logic      [31:0]         PRDATA_O,
  output logic                     PREADY_O,
  output logic                     PSLVERR_O,
  // Conversion results, channel 0 is A
  input  wire logic                RESULT_VALID_I,
  input  wire logic [NUM_CH*RES_W-1:0] RESULT_I,
  // Interrupt
  output logic                     IRQ_O
);
  import atc_pkg::*;

  // Register map, one aligned 32-bit word each:
  //   0x00 alert flag status, read clears; bit 2n under, bit 2n+1 over, n = A..D
  //   0x04 lower limit setting, select in 15:12, limit field in 11:0
  //   0x08 upper limit setting, same layout as the lower one
  //   0x0c interrupt status, write one to clear; bit 0 any under, bit 1 any over
  //   0x10 interrupt mask, same layout as the interrupt status
  // Writes to the flag status word and to unmapped words are dropped.
  // Unmapped accesses answer with an error and read zero.
  // The select bits are stored and read back but steer nothing here;
  // the serial transport that uses them sits outside this block.
  // Every access takes exactly one wait-free access cycle after setup,
  // so a master never sees a stretched transfer from this slave.

  localparam int FLAG_W = 2 * NUM_CH;

  logic [ATC_LIM_W-1:0]  lower_lim_q;
  logic [ATC_SEL_W-1:0]  lower_sel_q;
  logic [ATC_LIM_W-1:0]  upper_lim_q;
  logic [ATC_SEL_W-1:0]  upper_sel_q;
  logic [ATC_IRQ_W-1:0]  irq_stat_q;
  logic [ATC_IRQ_W-1:0]  irq_stat_d;
  logic [ATC_IRQ_W-1:0]  irq_mask_q;
  logic [31:0]           prdata_q;
  logic                  pready_q;
  logic                  pslverr_q;
  logic                  irq_q;

  logic [RES_W-1:0]      low_lim;
  logic [RES_W-1:0]      high_lim;
  logic [FLAG_W-1:0]     flags;
  logic [NUM_CH-1:0]     under_evt;
  logic [NUM_CH-1:0]     over_evt;
  logic                  any_under;
  logic                  any_over;

  // Per-register write strobes
  logic                  wr_lower;
  logic                  wr_upper;
  logic                  wr_istat;
  logic                  wr_imask;

  // Per-register read words, already padded to the bus width
  logic [31:0]           rd_status;
  logic [31:0]           rd_lower;
  logic [31:0]           rd_upper;
  logic [31:0]           rd_istat;
  logic [31:0]           rd_imask;
  logic [31:0]           rd_mux;

  // Access qualifiers and interrupt bookkeeping
  logic                  rd_setup;
  logic                  bad_setup;
  logic [ATC_IRQ_W-1:0]  irq_clr;
  logic [ATC_IRQ_W-1:0]  irq_set;
  logic [ATC_IRQ_W-1:0]  irq_pend;

  // APB decode: no wait state, answer on the first access cycle
  wire setup_ph   = PSEL_I && !PENABLE_I;
  wire access_ph  = PSEL_I && PENABLE_I && pready_q;
  wire wr_en      = access_ph && PWRITE_I;
  wire rd_en      = access_ph && !PWRITE_I;
  wire hit_status = PADDR_I == ATC_ADDR_STATUS;
  wire hit_lower  = PADDR_I == ATC_ADDR_LOWER;
  wire hit_upper  = PADDR_I == ATC_ADDR_UPPER;
  wire hit_istat  = PADDR_I == ATC_ADDR_IRQ_STAT;
  wire hit_imask  = PADDR_I == ATC_ADDR_IRQ_MASK;
  wire mapped     = hit_status | hit_lower | hit_upper | hit_istat | hit_imask;
  wire status_clr = rd_en && hit_status;

  // Write strobes; a write to the flag status word has no target on purpose
  assign wr_lower  = wr_en && hit_lower;
  assign wr_upper  = wr_en && hit_upper;
  assign wr_istat  = wr_en && hit_istat;
  assign wr_imask  = wr_en && hit_imask;

  // Setup-time qualifiers; read data is snapshotted at the setup edge
  assign rd_setup  = setup_ph && !PWRITE_I;
  assign bad_setup = setup_ph && !mapped;

  assign low_lim  = {lower_lim_q, ATC_LOW_FILL};
  assign high_lim = {upper_lim_q, ATC_HIGH_FILL};

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      atc_chan_cmp #(
        .RES_W (RES_W)
      ) u_cmp (
        .clk_i       (CLK_SYS_I),
        .rst_i       (SYS_RST_I),
        .valid_i     (RESULT_VALID_I),
        .result_i    (RESULT_I[g*RES_W +: RES_W]),
        .low_lim_i   (low_lim),
        .high_lim_i  (high_lim),
        // read of status clears all pairs
        .clr_i       (status_clr),
        .under_o     (flags[2*g+ATC_UNDER_BIT]),
        .over_o      (flags[2*g+ATC_OVER_BIT]),
        .under_evt_o (under_evt[g]),
        .over_evt_o  (over_evt[g])
      );
    end
  endgenerate

  assign any_under = |under_evt;
  assign any_over  = |over_evt;

  // Write-one-to-clear vector and new-event set vector
  assign irq_clr                = wr_istat ? PWDATA_I[ATC_IRQ_W-1:0] : '0;
  assign irq_set[ATC_IRQ_UNDER] = any_under;
  assign irq_set[ATC_IRQ_OVER]  = any_over;

  // New events win over a write-one-to-clear in the same cycle
  assign irq_stat_d = irq_set | (irq_stat_q & ~irq_clr);
  // Pending interrupts as they will stand after this edge
  assign irq_pend   = irq_stat_d & irq_mask_q;

  // Read words; bits above each register's width read as zero
  assign rd_status = {{(32-FLAG_W){1'b0}}, flags};
  assign rd_lower  = {16'h0000, lower_sel_q, lower_lim_q};
  assign rd_upper  = {16'h0000, upper_sel_q, upper_lim_q};
  assign rd_istat  = {{(32-ATC_IRQ_W){1'b0}}, irq_stat_q};
  assign rd_imask  = {{(32-ATC_IRQ_W){1'b0}}, irq_mask_q};

  // One-hot and-or select; flags shown as they stand before this read clears them
  assign rd_mux = ({32{hit_status}} & rd_status) |
                  ({32{hit_lower}}  & rd_lower)  |
                  ({32{hit_upper}}  & rd_upper)  |
                  ({32{hit_istat}}  & rd_istat)  |
                  ({32{hit_imask}}  & rd_imask);

  // limit field of the lower setting
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      lower_lim_q <= ATC_LOWER_RST;
    end else if (wr_lower) begin
      lower_lim_q <= PWDATA_I[ATC_LIM_W-1:0];
    end
  end

  // select bits of the lower setting
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      lower_sel_q <= ATC_LOWER_SEL_RST;
    end else if (wr_lower) begin
      lower_sel_q <= PWDATA_I[ATC_SEL_LSB +: ATC_SEL_W];
    end
  end

  // limit field of the upper setting
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      upper_lim_q <= ATC_UPPER_RST;
    end else if (wr_upper) begin
      upper_lim_q <= PWDATA_I[ATC_LIM_W-1:0];
    end
  end

  // select bits of the upper setting reset to zero
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      upper_sel_q <= ATC_UPPER_SEL_RST;
    end else if (wr_upper) begin
      upper_sel_q <= PWDATA_I[ATC_SEL_LSB +: ATC_SEL_W];
    end
  end

  // Interrupt status, updated every cycle
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= irq_stat_d;
    end
  end

  // Interrupt mask, plain read and write
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      irq_mask_q <= '0;
    end else if (wr_imask) begin
      irq_mask_q <= PWDATA_I[ATC_IRQ_W-1:0];
    end
  end

  // Interrupt registered so the output comes from a flop; in step with status
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |irq_pend;
    end
  end

  // Ready rises in the cycle after setup and stands for that one access cycle
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= setup_ph;
    end
  end

  // Error stands beside ready for an unmapped address
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= bad_setup;
    end
  end

  // Read data stands only in the access cycle, so the bus idles at zero
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      prdata_q <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_q <= rd_mux;
    end else if (access_ph) begin
      prdata_q <= 32'h0000_0000;
    end
  end

  assign PRDATA_O  = prdata_q;
  assign PREADY_O  = pready_q;
  assign PSLVERR_O = pslverr_q;
  assign IRQ_O     = irq_q;
endmodule

//--- sim/atc_top_props.sv
// Port checker for the alert threshold compare bank
`timescale 1ns/1ps
module atc_top_props #(
  parameter int NUM_CH = 4,
  parameter int RES_W  = 16
) (
  // Clock, reset and APB
  input wire logic                    CLK_SYS_I,
  input wire logic                    SYS_RST_I,
  input wire logic                    PSEL_I,
  input wire logic                    PENABLE_I,
  input wire logic                    PWRITE_I,
  input wire logic [7:0]              PADDR_I,
  input wire logic [31:0]             PWDATA_I,
  input wire logic [31:0]             PRDATA_O,
  input wire logic                    PREADY_O,
  input wire logic                    PSLVERR_O,
  // Results and interrupt
  input wire logic                    RESULT_VALID_I,
  input wire logic [NUM_CH*RES_W-1:0] RESULT_I,
  input wire logic                    IRQ_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SYS_RST_I);
  wire su  = PSEL_I && !PENABLE_I;
  wire hit = PADDR_I inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
  wire rs  = su && !PWRITE_I && PADDR_I == 8'h00 && !RESULT_VALID_I;
  wire ra  = PSEL_I && PENABLE_I && PREADY_O && !PWRITE_I && PADDR_I == 8'h00 && !RESULT_VALID_I;
  wire mz  = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && PADDR_I == 8'h10 && PWDATA_I[1:0] == 2'b00;
  chk_ready_once: assert property (su |=> PREADY_O ##1 !PREADY_O)
    else $error("ready not one cycle");
  chk_ready_idle: assert property (!PSEL_I |=> !PREADY_O)
    else $error("ready without setup");
  chk_err_unmapped: assert property (su && !hit |=> PSLVERR_O && PRDATA_O == 32'h0)
    else $error("unmapped not refused");
  chk_err_mapped: assert property (su && hit |=> !PSLVERR_O)
    else $error("mapped refused");
  chk_read_clears: assert property (rs ##1 ra ##1 !RESULT_VALID_I ##1 rs |=> PRDATA_O[7:0] == 8'h00)
    else $error("flags not cleared by read");
  chk_status_width: assert property (rs |=> PRDATA_O[31:8] == 24'h0)
    else $error("status upper bits set");
  chk_limit_width: assert property (su && !PWRITE_I && PADDR_I inside {8'h04, 8'h08} |=> PRDATA_O[31:16] == 16'h0)
    else $error("limit upper bits set");
  chk_mask_quiet: assert property (mz |-> ##2 !IRQ_O)
    else $error("irq high with mask zero");
  cover property (rs ##1 ra);
  cover property (su && !hit);
  cover property ($rose(IRQ_O));
endmodule
bind atc_top atc_top_props #(.NUM_CH(NUM_CH), .RES_W(RES_W)) atc_top_props_inst (
  .CLK_SYS_I(CLK_SYS_I), .SYS_RST_I(SYS_RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
  .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .RESULT_VALID_I(RESULT_VALID_I),
  .RESULT_I(RESULT_I), .IRQ_O(IRQ_O));

//--- sim/atc_conv_src.sv
// Converter stand-in that hands all four results over in one cycle
`timescale 1ns/1ps
module atc_conv_src (
  // Clock, reset and request
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        go_i,
  input  wire logic [63:0] res_i,
  // Results
  output logic             valid_o,
  output logic [63:0]      result_o
);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      valid_o  <= 1'b0;
      result_o <= 64'h0;
    end else begin
      valid_o  <= go_i;
      // Toggles outside valid so a stale result is never usable
      result_o <= go_i ? res_i : ~result_o;
    end
  end
endmodule

//--- sim/testbench.sv
// Self-checking bench for the alert threshold compare bank
`timescale 1ns/1ps
module testbench;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [63:0] res = 64'h0, result;
  logic        pready, pslverr, irq, valid, err;
  int          errors = 0, check_count = 0;
  always #20 clk = ~clk;
  atc_top atc_top_inst (.CLK_SYS_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .RESULT_VALID_I(valid), .RESULT_I(result),
    .IRQ_O(irq));
  atc_conv_src atc_conv_src_inst (.clk_i(clk), .rst_i(rst), .go_i(go), .res_i(res),
    .valid_o(valid), .result_o(result));
  task automatic conclude;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Look mid-cycle, where the registered answer has settled
    do begin
      @(negedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      errors++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    // Hold the request through the rising edge that takes the access
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, rd, e);
  endtask
  task automatic ichk(input string n, input logic e);
    @(negedge clk);
    chk(n, {31'h0, irq}, {31'h0, e});
    @(posedge clk);
  endtask
  task automatic conv(input logic [63:0] r);
    go <= 1'b1;
    res <= r;
    @(posedge clk);
    go <= 1'b0;
    repeat (5) @(posedge clk);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc("lower reset", 8'h04, 32'h800);
    rdc("upper reset", 8'h08, 32'h7ff);
    rdc("flags reset", 8'h00, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped", {31'h0, err}, 32'h1);
    apb(1'b1, 8'h04, 32'h3123);
    apb(1'b1, 8'h08, 32'ha456);
    rdc("lower rw", 8'h04, 32'h3123);
    rdc("upper rw", 8'h08, 32'ha456);
    // Limits 0x1230 and 0x456f; B and C sit exactly on them
    conv(64'h4570_456f_1230_122f);
    rdc("edge flags", 8'h00, 32'h81);
    rdc("cleared", 8'h00, 32'h0);
    conv(64'hffff_0000_122f_4570);
    conv(64'h2000_2000_2000_2000);
    rdc("sticky", 8'h00, 32'h96);
    rdc("irq status", 8'h0c, 32'h3);
    apb(1'b1, 8'h10, 32'h3);
    ichk("irq on", 1'b1);
    apb(1'b1, 8'h0c, 32'h3);
    ichk("irq off", 1'b0);
    apb(1'b1, 8'h10, 32'h2);
    conv(64'h2000_2000_2000_0000);
    ichk("irq masked", 1'b0);
    rdc("masked status", 8'h0c, 32'h1);
    apb(1'b1, 8'h10, 32'h0);
    conclude();
  end
endmodule
